// file: hw/exposure_strobe_pkg.sv
package exposure_strobe_pkg;

    localparam int CLK_PERIOD_PS = 4000;

    // Trigger to exposure start delay, per model class
    localparam int START_DELAY_SMALL_NS = 270;
    localparam int START_DELAY_LARGE_NS = 3500;
    localparam int START_DELAY_SMALL_CYC = (START_DELAY_SMALL_NS * 1000 + CLK_PERIOD_PS - 1)
                                           / CLK_PERIOD_PS;
    localparam int START_DELAY_LARGE_CYC = (START_DELAY_LARGE_NS * 1000 + CLK_PERIOD_PS - 1)
                                           / CLK_PERIOD_PS;

    // Fixed exposure tail after trigger release in bulb mode, in ns
    localparam int TAIL_A_NS = 13720;
    localparam int TAIL_B_NS = 14260;
    localparam int TAIL_C_NS = 28000;
    localparam int TAIL_A_CYC = (TAIL_A_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TAIL_B_CYC = (TAIL_B_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TAIL_C_CYC = (TAIL_C_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Least trigger pulse width, in ns
    localparam int MIN_TRIG_NS = 100000;
    localparam int MIN_TRIG_CYC = (MIN_TRIG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Least programmed pulse and its step, in us
    localparam int PULSE_MIN_US = 1000;
    localparam int PULSE_STEP_US = 100;

    localparam int CNT_W = 32;
    localparam int DELAY_W = 12;

    typedef enum logic [1:0]
    {
        MODEL_SMALL_A = 2'b00,
        MODEL_SMALL_B = 2'b01,
        MODEL_LARGE   = 2'b10
    } model_t;

    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b000,
        ST_DELAY = 3'b001,
        ST_EXPO  = 3'b010,
        ST_TAIL  = 3'b011,
        ST_WAIT  = 3'b100
    } state_t;

endpackage

// file: hw/trigger_edge_detect.sv
module trigger_edge_detect
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic trigger_in,
    input  wire logic active_falling,
    output logic      active_edge,
    output logic      release_edge,
    output logic      trig_level
);
    logic prev;
    logic next_prev;

    always_comb
    begin
        next_prev = trig_level;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            prev <= 1'b0;
        else
            prev <= next_prev;
    end

    // Polarity folded so downstream logic sees active-high trigger
    assign trig_level   = trigger_in ^ active_falling;
    // History kept folded, so reset at idle gives no edge; a polarity swap with the input held still reads as an edge
    assign active_edge  = trig_level && !prev;
    assign release_edge = !trig_level && prev;
endmodule

// file: hw/exposure_strobe_timing.sv
// Summary of operation
// R1: A trigger starts exposure and raises the strobe after the model's start delay.
// R2: In trigger-width mode exposure continues for a fixed model tail after trigger release.
// R3: The strobe stays high through that tail so it spans the true exposure.
// R4: In equal-exposure mode the strobe rises only when rolling reset has completed.
// R5: In equal-exposure mode the strobe falls when rolling readout begins.
// R6: The equal-exposure pulse is made only if exposure time exceeds the rolling reset period.
// R7: Software programs the pulse width to at least 1 ms in 0.1 ms steps.
// R8: The active trigger edge is selectable, rising by default, and pulses last 100 us or more.
// R9: Outside equal-exposure mode the strobe is high during the sensor exposure.
// R10: If equal-exposure mode cannot be met the strobe stays low for that frame.
module exposure_strobe_timing
(
    input  wire logic                         clk,
    input  wire logic                         srst,
    input  wire logic                         trigger_in,
    input  wire logic                         trigger_falling,
    input  wire logic                         trigger_width_exposure_mode,
    input  wire logic                         equal_exposure_pulse,
    input  wire exposure_strobe_pkg::model_t  model,
    input  wire logic [exposure_strobe_pkg::CNT_W-1:0] exposure_cycles,
    input  wire logic [exposure_strobe_pkg::CNT_W-1:0] reset_period_cycles,
    input  wire logic                         rolling_reset_done,
    input  wire logic                         rolling_readout_start,
    output logic                              strobe_out,
    output logic                              exposure_active,
    output logic                              trigger_too_short
);
    import exposure_strobe_pkg::*;

    state_t             state;
    state_t             next_state;
    logic [CNT_W-1:0]   count;
    logic [CNT_W-1:0]   next_count;
    logic [CNT_W-1:0]   width_count;
    logic [CNT_W-1:0]   next_width_count;
    logic               pulse_ok;
    logic               next_pulse_ok;
    logic               strobe;
    logic               next_strobe;
    logic               too_short;
    logic               next_too_short;
    logic               active_edge;
    logic               release_edge;
    logic               trig_level;
    logic               released;
    logic               next_released;

    trigger_edge_detect u_edge
    (
        .clk            (clk),
        .srst           (srst),
        .trigger_in     (trigger_in),
        .active_falling (trigger_falling),
        .active_edge    (active_edge),
        .release_edge   (release_edge),
        .trig_level     (trig_level)
    );

    // Cycle counts round up, so strobe edges never lead the sensor
    function automatic logic [CNT_W-1:0] start_delay(input model_t m);
        if (m == MODEL_LARGE)
            return CNT_W'(START_DELAY_LARGE_CYC);
        else
            return CNT_W'(START_DELAY_SMALL_CYC);
    endfunction

    function automatic logic [CNT_W-1:0] tail_len(input model_t m);
        if (m == MODEL_SMALL_A)
            return CNT_W'(TAIL_A_CYC);
        else if (m == MODEL_SMALL_B)
            return CNT_W'(TAIL_B_CYC);
        else
            return CNT_W'(TAIL_C_CYC);
    endfunction

    always_comb
    begin
        next_state       = state;
        next_count       = count;
        next_width_count = width_count;
        next_pulse_ok    = pulse_ok;
        next_strobe      = strobe;
        next_too_short   = too_short;
        next_released    = released;

        // Pulse-width check only flags; a short trigger is still honoured
        if (trig_level && width_count != CNT_W'(MIN_TRIG_CYC))
            next_width_count = width_count + CNT_W'(1);
        if (release_edge)
        begin
            next_too_short   = (width_count < CNT_W'(MIN_TRIG_CYC)); // R8
            next_width_count = '0;
        end

        case (state)
            ST_IDLE:
            begin
                next_strobe = 1'b0;
                if (active_edge) // R8
                begin
                    next_state    = ST_DELAY;
                    next_count    = start_delay(model) - CNT_W'(1); // R1
                    next_pulse_ok = exposure_cycles > reset_period_cycles; // R6
                    next_released = 1'b0;
                end
            end
            ST_DELAY:
            begin
                if (release_edge)
                    next_released = 1'b1;
                if (count == '0)
                begin
                    if (equal_exposure_pulse)
                    begin
                        next_state  = ST_WAIT;
                        next_strobe = 1'b0;
                    end
                    else
                    begin
                        next_state  = ST_EXPO;
                        next_strobe = 1'b1; // R1 R9
                    end
                    next_count = exposure_cycles;
                end
                else
                    next_count = count - CNT_W'(1);
            end
            ST_WAIT:
            begin
                // Strobe held low until every row is integrating
                if (!pulse_ok)
                begin
                    next_strobe = 1'b0; // R10
                    if (rolling_readout_start)
                        next_state = ST_IDLE;
                end
                else if (rolling_reset_done)
                begin
                    next_strobe = 1'b1; // R4
                    next_state  = ST_EXPO;
                end
                else if (rolling_readout_start)
                begin
                    // Readout overtook reset, so no clean window this frame
                    next_state = ST_IDLE; // R5
                end
            end
            ST_EXPO:
            begin
                if (equal_exposure_pulse)
                begin
                    if (rolling_readout_start)
                    begin
                        next_strobe = 1'b0; // R5
                        next_state  = ST_IDLE;
                    end
                end
                else if (trigger_width_exposure_mode)
                begin
                    // A release seen during the start delay still starts the tail
                    if (release_edge || released)
                    begin
                        next_state = ST_TAIL; // R2
                        next_count = tail_len(model) - CNT_W'(1);
                    end
                end
                else if (count <= CNT_W'(1))
                begin
                    next_strobe = 1'b0; // R9
                    next_state  = ST_IDLE;
                end
                else
                    next_count = count - CNT_W'(1);
            end
            ST_TAIL:
            begin
                next_strobe = 1'b1; // R3
                if (count == '0)
                begin
                    next_strobe = 1'b0;
                    next_state  = ST_IDLE;
                end
                else
                    next_count = count - CNT_W'(1); // R2
            end
            default:
            begin
                next_state  = ST_IDLE;
                next_strobe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state       <= ST_IDLE;
            count       <= '0;
            width_count <= '0;
            pulse_ok    <= 1'b0;
            strobe      <= 1'b0;
            too_short   <= 1'b0;
            released    <= 1'b0;
        end
        else
        begin
            state       <= next_state;
            count       <= next_count;
            width_count <= next_width_count;
            pulse_ok    <= next_pulse_ok;
            strobe      <= next_strobe;
            too_short   <= next_too_short;
            released    <= next_released;
        end
    end

    assign strobe_out        = strobe;
    assign exposure_active   = (state == ST_EXPO) || (state == ST_TAIL) || (state == ST_WAIT);
    assign trigger_too_short = too_short;
endmodule

// file: verif/exposure_strobe_timing_properties.sv
module exposure_strobe_timing_properties
(
    input wire logic                        clk,
    input wire logic                        srst,
    input wire logic                        trigger_in,
    input wire logic                        trigger_falling,
    input wire logic                        trigger_width_exposure_mode,
    input wire logic                        equal_exposure_pulse,
    input wire exposure_strobe_pkg::model_t model,
    input wire logic [31:0]                 exposure_cycles,
    input wire logic [31:0]                 reset_period_cycles,
    input wire logic                        rolling_reset_done,
    input wire logic                        rolling_readout_start,
    input wire logic                        strobe_out,
    input wire logic                        exposure_active
);
    import exposure_strobe_pkg::*;
    logic        act;
    logic [31:0] hi_cnt;
    logic [31:0] rel_cnt;
    logic [31:0] tail;
    assign act = trigger_in ^ trigger_falling;
    assign tail = model == MODEL_LARGE ? 32'(TAIL_C_CYC) :
                  model == MODEL_SMALL_B ? 32'(TAIL_B_CYC) : 32'(TAIL_A_CYC);
    // Run lengths of strobe high and of trigger released
    always_ff @(posedge clk)
    begin
        hi_cnt <= (srst || !strobe_out) ? '0 : hi_cnt + 1;
        rel_cnt <= (srst || act) ? '0 : rel_cnt + 1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_rise_soon;
        ##[1:2] strobe_out;
    endsequence
    sequence s_fall_soon;
        ##[1:2] !strobe_out;
    endsequence
    property p_start;
        $rose(strobe_out) && !equal_exposure_pulse && model != MODEL_LARGE
            |-> $past(act, 69) && !$past(act, 70);
    endproperty
    a_start: assert property (p_start) else $error("strobe start delay wrong");
    property p_std_len;
        $fell(strobe_out) && !trigger_width_exposure_mode && !equal_exposure_pulse
            |-> hi_cnt == exposure_cycles;
    endproperty
    a_std_len: assert property (p_std_len) else $error("strobe width wrong");
    property p_bulb_hold;
        strobe_out && trigger_width_exposure_mode && act |=> strobe_out;
    endproperty
    a_bulb_hold: assert property (p_bulb_hold) else $error("strobe dropped");
    property p_bulb_tail;
        $fell(strobe_out) && trigger_width_exposure_mode
            |-> rel_cnt > tail && rel_cnt <= tail + 4;
    endproperty
    a_bulb_tail: assert property (p_bulb_tail) else $error("tail length wrong");
    property p_pulse_rise;
        $rose(strobe_out) && equal_exposure_pulse
            |-> $past(rolling_reset_done) || $past(rolling_reset_done, 2);
    endproperty
    a_pulse_rise: assert property (p_pulse_rise) else $error("early pulse rise");
    property p_pulse_go;
        equal_exposure_pulse && rolling_reset_done && exposure_cycles > reset_period_cycles
            |-> s_rise_soon;
    endproperty
    a_pulse_go: assert property (p_pulse_go) else $error("pulse missing");
    property p_pulse_fall;
        equal_exposure_pulse && strobe_out && rolling_readout_start |-> s_fall_soon;
    endproperty
    a_pulse_fall: assert property (p_pulse_fall) else $error("late pulse fall");
    property p_pulse_off;
        equal_exposure_pulse && exposure_cycles <= reset_period_cycles |-> !strobe_out;
    endproperty
    a_pulse_off: assert property (p_pulse_off) else $error("pulse not held off");
    property p_expo;
        strobe_out && !equal_exposure_pulse |-> exposure_active;
    endproperty
    a_expo: assert property (p_expo) else $error("strobe outside exposure");
endmodule
bind exposure_strobe_timing exposure_strobe_timing_properties u_props (.clk, .srst,
    .trigger_in, .trigger_falling, .trigger_width_exposure_mode, .equal_exposure_pulse,
    .model, .exposure_cycles, .reset_period_cycles, .rolling_reset_done,
    .rolling_readout_start, .strobe_out, .exposure_active);

// file: verif/trigger_lamp_model.sv
module trigger_lamp_model
(
    input  wire logic clk,
    input  wire logic strobe_out,
    output logic      trigger_in,
    output logic      trigger_falling
);
    timeunit 1ns;
    timeprecision 1ps;
    int lit = 0;
    initial
    begin
        trigger_in = 1'b0;
        trigger_falling = 1'b0;
    end
    // Lamp burns while strobe is high
    always @(posedge clk)
        if (strobe_out)
            lit <= lit + 1;
    // Idle level follows polarity so the swap itself is no edge
    task automatic set_pol(input logic f);
        @(posedge clk);
        trigger_falling <= f;
        trigger_in <= f;
    endtask
    task automatic fire(input int w);
        @(posedge clk);
        trigger_in <= !trigger_falling;
        repeat (w) @(posedge clk);
        trigger_in <= trigger_falling;
    endtask
endmodule

// file: verif/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import exposure_strobe_pkg::*;
    logic        clk = 0;
    logic        srst = 1;
    logic        bulb = 0;
    logic        equal_mode = 0;
    logic        done = 0;
    logic        rdo = 0;
    logic        trig;
    logic        fall;
    logic        strobe;
    logic        active;
    logic        short_flag;
    logic        act_q = 0;
    logic        st_q = 0;
    model_t      model = MODEL_SMALL_A;
    logic [31:0] ex = 32'h64;
    logic [31:0] rp = 32'h32;
    int num_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int e_cyc, r_cyc, up_cyc, dn_cyc, d_cyc, s_cyc;
    initial
    begin
        forever #2 clk = ~clk;
    end
    exposure_strobe_timing DUT (.clk(clk), .srst(srst), .trigger_in(trig),
        .trigger_falling(fall), .trigger_width_exposure_mode(bulb),
        .equal_exposure_pulse(equal_mode), .model(model), .exposure_cycles(ex),
        .reset_period_cycles(rp), .rolling_reset_done(done), .rolling_readout_start(rdo),
        .strobe_out(strobe), .exposure_active(active), .trigger_too_short(short_flag));
    trigger_lamp_model part (.clk(clk), .strobe_out(strobe), .trigger_in(trig),
        .trigger_falling(fall));
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("Error %s expected %0d seen %0d", n, e, s);
        end
    endtask
    // Event times as seen at the sampling edge
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        act_q <= trig ^ fall;
        st_q <= strobe;
        if ((trig ^ fall) && !act_q)
            e_cyc <= cyc;
        if (!(trig ^ fall) && act_q)
            r_cyc <= cyc;
        if (strobe && !st_q)
            up_cyc <= cyc;
        if (!strobe && st_q)
            dn_cyc <= cyc;
        if (done)
            d_cyc <= cyc;
        if (rdo)
            s_cyc <= cyc;
        if (cyc == 80000)
        begin
            num_errors++;
            complete_run();
        end
    end
    task automatic frame(input logic b, input logic q, input model_t m, input logic f,
                         input int w, input logic ok);
        int l0;
        int r;
        int t;
        r = 50 + $urandom % 50;
        t = m == MODEL_LARGE ? TAIL_C_CYC : m == MODEL_SMALL_B ? TAIL_B_CYC : TAIL_A_CYC;
        @(posedge clk);
        bulb <= b;
        equal_mode <= q;
        model <= m;
        rp <= 32'(r);
        ex <= ok ? 32'(r + 100 + $urandom % 100) : 32'(r);
        part.set_pol(f);
        l0 = part.lit;
        fork
            part.fire(w);
            if (q)
            begin
                repeat (300) @(posedge clk);
                done <= 1'b1;
                @(posedge clk);
                done <= 1'b0;
                // Pulse length scaled far below the host floor to keep the run short
                repeat (ex) @(posedge clk);
                rdo <= 1'b1;
                @(posedge clk);
                rdo <= 1'b0;
            end
        join
        for (int i = 0; i < 8000 && (strobe || active); i++)
            @(posedge clk);
        repeat (5) @(posedge clk);
        if (!q)
            check("delay", up_cyc - e_cyc, (m == MODEL_LARGE ? START_DELAY_LARGE_CYC :
                  START_DELAY_SMALL_CYC) + 1);
        if (!b && !q)
            check("width", dn_cyc - up_cyc, ex);
        if (b)
            check("tail", dn_cyc - r_cyc > t && dn_cyc - r_cyc <= t + 4, 1);
        if (q && ok)
            check("pulse", (up_cyc - d_cyc) inside {1, 2} && (dn_cyc - s_cyc) inside {1, 2},
                  1);
        check("lamp", part.lit - l0, (q && !ok) ? 0 : dn_cyc - up_cyc);
        check("short", short_flag, w < MIN_TRIG_CYC);
        check("idle", active, 0);
    endtask
    initial
    begin
        void'($urandom(32'hDD538E63));
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        frame(0, 0, MODEL_SMALL_A, 0, MIN_TRIG_CYC, 1);
        frame(1, 0, MODEL_LARGE, 1, MIN_TRIG_CYC, 1);
        frame(0, 1, MODEL_SMALL_A, 0, 1000, 1);
        frame(0, 1, MODEL_SMALL_B, 0, 1000, 0);
        frame(1, 0, MODEL_SMALL_B, 0, 1000, 1);
        complete_run();
    end
endmodule
